// [hw/rptr_mgmt_pkg.sv]
package rptr_mgmt_pkg;
  localparam int PORTS = 8;
  localparam int CNT_W = 32;
  localparam int REG_W = 16;
  localparam int ID_W = 5;
  localparam logic [4:0] REG_CONFIG = 5'h00;
  localparam logic [4:0] REG_PAGE = 5'h01;
  localparam logic [4:0] REG_IDENT = 5'h05;
  localparam logic [4:0] REG_HUB_LO = 5'h06;
  localparam logic [4:0] REG_HUB_HI = 5'h07;
  localparam logic [4:0] REG_CNT_BASE = 5'h08;
  localparam logic [4:0] PAGE0_CNT = 5'h06;
  localparam logic [4:0] PAGE1_CNT = 5'h02;
  localparam logic [2:0] PAGE1_FIRST = 3'h6;
  localparam logic [4:0] ID_ILLEGAL = 5'h1F;
  localparam logic [4:0] ID_RESET = 5'h00;
  localparam int IDENT_LOAD_BIT = 7;
  localparam int IDENT_ERR_BIT = 5;
  localparam int CFG_EN_BIT = 0;
  localparam int PAGE_BIT = 0;
  localparam logic [5:0] PRE_LEN = 6'h20;
  localparam logic [5:0] EE_LAST = 6'h1F;
  localparam logic [5:0] OP_LAST = 6'h01;
  localparam logic [5:0] ADR_LAST = 6'h09;
  localparam logic [5:0] TA_LAST = 6'h01;
  localparam logic [5:0] DAT_LAST = 6'h0F;
  localparam logic [1:0] OP_RD = 2'h2;
  localparam logic [1:0] OP_WR = 2'h1;
  typedef enum logic [2:0] {
    S_PRE = 3'b000,
    S_ST = 3'b001,
    S_OP = 3'b010,
    S_ADR = 3'b011,
    S_TA = 3'b100,
    S_DAT = 3'b101
  } mgmt_state_t;
endpackage : rptr_mgmt_pkg

// [hw/repeater_id_and_port_counters.sv]
`timescale 1ns/1ps
// Summary of operation
// [RULE1] Load-complete flag sets once all EEPROM bits have been taken.
// [RULE2] ID-conflict flag sets on a seen ID clash or when ID equals 1Fh.
// [RULE3] ID-conflict flag stays set until software writes the register.
// [RULE4] The five ID bits drive the backplane vector outputs directly.
// [RULE5] Only frames addressed to the current ID are answered.
// [RULE6] ID strap pins are captured into the ID field at reset release.
// [RULE7] Controller must use the new ID for all later accesses.
// [RULE8] Controller must never write 1Fh into the ID field.
// [RULE9] Software writes zero to the reserved identity bit; reads undefined.
// [RULE10] First 16 EEPROM bits fill low hub tag, earliest bit at bit 0.
// [RULE11] Next 16 EEPROM bits fill high hub tag, earliest bit at bit 0.
// [RULE12] Every port has counters that software can read and preset.
// [RULE13] Ports 0-5 counters live in page 0, ports 6-7 in page 1.
// [RULE14] Counters wrap to zero, never saturate, raise no interrupt.
// [RULE15] All port counters clear to zero under chip reset.
// [RULE16] Counters are 32 bits shown through a 16-bit window in halves.
// [RULE17] First read latches whole count and gives upper half; next, lower.
// [RULE18] Any other register access between halves resets the half mux.
// [RULE19] Software writes a counter as two back-to-back halves.
// [RULE20] Writing zero clears a counter; reading leaves it unchanged.
// [RULE21] Software presets counters only with counting disabled.
// [RULE22] Short-event counter counts every carrier event below the limit.
// [RULE23] Split write takes upper half first; counter updates on second.
module repeater_id_and_port_counters
  import rptr_mgmt_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_reset,
  input wire logic i_ce,
  input wire logic [ID_W-1:0] i_id_strap_pins,
  input wire logic i_mdc,
  input wire logic i_mdio_in,
  input wire logic i_ee_bit,
  input wire logic i_ee_bit_valid,
  input wire logic i_id_clash,
  input wire logic [PORTS-1:0] i_short_event,
  output logic o_mdio_out,
  output logic o_mdio_oe,
  output logic [ID_W-1:0] o_backplane_vector_out,
  output logic o_stats_count_enable,
  output logic o_eeprom_load_complete
);
  logic mdc_s1, mdc_s2, mdc_s3, mdio_s1, mdio_s2;
  logic [ID_W-1:0] strap_s1, strap_s2;
  mgmt_state_t state_q;
  logic [5:0] bcnt_q;
  logic [1:0] op_q;
  logic [9:0] adr_q;
  logic [REG_W-1:0] sh_q;
  logic match_q, rd_q, out_q, oe_q;
  logic page_q, count_en_q, rst_q, id_err_q, eeprom_load_complete_q;
  logic [ID_W-1:0] own_repeater_number_q;
  logic [CNT_W-1:0] ee_sr_q;
  logic [5:0] ee_cnt_q;
  logic [CNT_W-1:0] hold_q;
  logic [REG_W-1:0] wr_hi_q;
  logic half_q, half_wr_q;
  logic [2:0] half_idx_q;
  logic [CNT_W-1:0] cnt_q [PORTS];

  // Pins come from another clock; two stages before any use
  always_ff @(posedge i_mclk) begin
    if (i_ce) begin
      mdc_s1 <= i_mdc;
      mdc_s2 <= mdc_s1;
      mdc_s3 <= mdc_s2;
      mdio_s1 <= i_mdio_in;
      mdio_s2 <= mdio_s1;
      strap_s1 <= i_id_strap_pins;
      strap_s2 <= strap_s1;
    end
  end

  wire rise = i_ce & mdc_s2 & ~mdc_s3;
  wire bit_in = mdio_s2;
  wire [9:0] adr_full = {adr_q[8:0], bit_in};
  wire adr_done = rise && state_q == S_ADR && bcnt_q == ADR_LAST;
  wire dev_hit = adr_full[9:5] == own_repeater_number_q;
  wire acc_rd = adr_done && op_q == OP_RD && dev_hit; // [RULE5]
  wire wr_done = rise && state_q == S_DAT && bcnt_q == DAT_LAST &&
    !rd_q && match_q; // [RULE5]
  wire acc_any = acc_rd | wr_done;
  wire [4:0] acc_reg = adr_done ? adr_full[4:0] : adr_q[4:0];
  wire [REG_W-1:0] wdata = {sh_q[REG_W-2:0], bit_in};

  // Counter window placement depends on page
  wire [4:0] cnt_off = acc_reg - REG_CNT_BASE;
  wire cnt_sel = acc_reg >= REG_CNT_BASE &&
    cnt_off < (page_q ? PAGE1_CNT : PAGE0_CNT); // [RULE13]
  wire [2:0] cnt_idx = cnt_off[2:0] +
    (page_q ? PAGE1_FIRST : 3'h0); // [RULE13]
  wire second = half_q && cnt_sel && cnt_idx == half_idx_q &&
    half_wr_q == wr_done;
  wire wr_commit = wr_done & second; // [RULE23]
  wire [CNT_W-1:0] commit_val = {wr_hi_q, wdata}; // [RULE23]
  wire wr_ident = wr_done && acc_reg == REG_IDENT;
  wire wr_cfg = wr_done && acc_reg == REG_CONFIG;
  wire wr_page = wr_done && acc_reg == REG_PAGE;

  // Upper half from live count, lower half from the latched copy
  wire [REG_W-1:0] cnt_rd = second ? hold_q[REG_W-1:0] :
    cnt_q[cnt_idx][CNT_W-1:REG_W]; // [RULE16] [RULE17]
  // Reserved identity bit reads zero
  wire [REG_W-1:0] ident_rd = {8'h00, eeprom_load_complete_q, 1'b0, id_err_q,
    own_repeater_number_q}; // [RULE9]
  wire [REG_W-1:0] rd_data =
    cnt_sel ? cnt_rd :
    acc_reg == REG_IDENT ? ident_rd :
    acc_reg == REG_HUB_LO ? ee_sr_q[REG_W-1:0] :
    acc_reg == REG_HUB_HI ? ee_sr_q[CNT_W-1:REG_W] :
    acc_reg == REG_CONFIG ? {15'h0000, count_en_q} :
    acc_reg == REG_PAGE ? {15'h0000, page_q} : 16'h0000;

  // Serial frame sequencer: preamble, start, op, address, turnaround
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      state_q <= S_PRE;
      bcnt_q <= 6'h00;
      op_q <= 2'h0;
      adr_q <= 10'h000;
      match_q <= 1'b0;
      rd_q <= 1'b0;
    end else if (rise) begin
      case (state_q)
        S_PRE: begin
          if (bit_in) begin
            bcnt_q <= (bcnt_q == PRE_LEN) ? bcnt_q : bcnt_q + 6'h01;
          end else begin
            state_q <= (bcnt_q == PRE_LEN) ? S_ST : S_PRE;
            bcnt_q <= 6'h00;
          end
        end
        S_ST: begin
          state_q <= bit_in ? S_OP : S_PRE;
        end
        S_OP: begin
          op_q <= {op_q[0], bit_in};
          state_q <= (bcnt_q == OP_LAST) ? S_ADR : S_OP;
          bcnt_q <= (bcnt_q == OP_LAST) ? 6'h00 : bcnt_q + 6'h01;
        end
        S_ADR: begin
          adr_q <= adr_full;
          if (bcnt_q == ADR_LAST) begin
            state_q <= S_TA;
            bcnt_q <= 6'h00;
            match_q <= dev_hit && (op_q == OP_RD || op_q == OP_WR);
            rd_q <= op_q == OP_RD;
          end else begin
            bcnt_q <= bcnt_q + 6'h01;
          end
        end
        S_TA: begin
          state_q <= (bcnt_q == TA_LAST) ? S_DAT : S_TA;
          bcnt_q <= (bcnt_q == TA_LAST) ? 6'h00 : bcnt_q + 6'h01;
        end
        S_DAT: begin
          state_q <= (bcnt_q == DAT_LAST) ? S_PRE : S_DAT;
          bcnt_q <= (bcnt_q == DAT_LAST) ? 6'h00 : bcnt_q + 6'h01;
        end
        default: begin
          state_q <= S_PRE;
          bcnt_q <= 6'h00;
        end
      endcase
    end
  end

  // Drive only the second turnaround bit, so the master has let go
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      sh_q <= 16'h0000;
      out_q <= 1'b0;
      oe_q <= 1'b0;
    end else if (acc_rd) begin
      sh_q <= rd_data;
    end else if (rise && state_q == S_TA) begin
      oe_q <= match_q & rd_q; // [RULE5]
      out_q <= (bcnt_q == TA_LAST) ? sh_q[REG_W-1] : 1'b0;
      if (bcnt_q == TA_LAST && rd_q) begin
        sh_q <= {sh_q[REG_W-2:0], 1'b0};
      end
    end else if (rise && state_q == S_DAT) begin
      if (rd_q) begin
        oe_q <= oe_q && bcnt_q != DAT_LAST;
        out_q <= (bcnt_q == DAT_LAST) ? 1'b0 : sh_q[REG_W-1];
        sh_q <= {sh_q[REG_W-2:0], 1'b0};
      end else begin
        sh_q <= wdata;
      end
    end
  end

  // Half mux: any non-pair access drops it
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      half_q <= 1'b0;
      half_wr_q <= 1'b0;
      half_idx_q <= 3'h0;
      hold_q <= 32'h00000000;
      wr_hi_q <= 16'h0000;
    end else if (i_ce && acc_any) begin
      half_q <= cnt_sel && !second; // [RULE18]
      half_wr_q <= wr_done;
      half_idx_q <= cnt_idx;
      if (cnt_sel && !second) begin
        hold_q <= cnt_q[cnt_idx]; // [RULE17]
        wr_hi_q <= wdata; // [RULE23]
      end
    end
  end

  // Strap capture needs the cycle after reset falls
  always_ff @(posedge i_mclk) begin
    if (i_ce) begin
      rst_q <= i_reset;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      own_repeater_number_q <= ID_RESET;
      count_en_q <= 1'b0;
      page_q <= 1'b0;
    end else if (i_ce) begin
      if (rst_q) begin
        own_repeater_number_q <= strap_s2; // [RULE6]
      end else if (wr_ident) begin
        own_repeater_number_q <= wdata[ID_W-1:0]; // [RULE4]
      end
      if (wr_cfg) begin
        count_en_q <= wdata[CFG_EN_BIT];
      end
      if (wr_page) begin
        page_q <= wdata[PAGE_BIT];
      end
    end
  end

  // Set wins over the clearing write
  wire err_set = i_id_clash ||
    own_repeater_number_q == ID_ILLEGAL; // [RULE2]
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      id_err_q <= 1'b0;
    end else if (i_ce) begin
      id_err_q <= err_set | (id_err_q & ~wr_ident); // [RULE3]
    end
  end

  // Shift right: earliest bit lands in bit 0 of the low tag
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      ee_sr_q <= 32'h00000000;
      ee_cnt_q <= 6'h00;
      eeprom_load_complete_q <= 1'b0;
    end else if (i_ce && i_ee_bit_valid && !eeprom_load_complete_q) begin
      ee_sr_q <= {i_ee_bit, ee_sr_q[CNT_W-1:1]}; // [RULE10] [RULE11]
      ee_cnt_q <= ee_cnt_q + 6'h01;
      eeprom_load_complete_q <= ee_cnt_q == EE_LAST; // [RULE1]
    end
  end

  // Event pulses arrive already classified against the short limit
  for (genvar p = 0; p < PORTS; p++) begin : g_cnt
    always_ff @(posedge i_mclk) begin
      if (i_reset) begin
        cnt_q[p] <= 32'h00000000; // [RULE15]
      end else if (i_ce) begin
        if (wr_commit && cnt_idx == 3'(p)) begin
          cnt_q[p] <= commit_val; // [RULE12] [RULE20]
        end else if (count_en_q && i_short_event[p]) begin
          cnt_q[p] <= cnt_q[p] + 32'h00000001; // [RULE14] [RULE22]
        end
      end
    end
  end

  assign o_mdio_out = out_q;
  assign o_mdio_oe = oe_q;
  assign o_backplane_vector_out = own_repeater_number_q; // [RULE4]
  assign o_stats_count_enable = count_en_q;
  assign o_eeprom_load_complete = eeprom_load_complete_q;

  chk_load_flag_set: assert property (@(posedge i_mclk) // [RULE1]
    disable iff (i_reset) i_ce && i_ee_bit_valid && !eeprom_load_complete_q &&
    ee_cnt_q == EE_LAST |=> eeprom_load_complete_q)
    else $error("load flag not set after last bit");
  chk_illegal_id_err: assert property (@(posedge i_mclk) // [RULE2]
    disable iff (i_reset) i_ce && own_repeater_number_q == ID_ILLEGAL
    |=> id_err_q) else $error("illegal id not flagged");
  chk_err_sticky: assert property (@(posedge i_mclk) // [RULE3]
    disable iff (i_reset) id_err_q && !(i_ce && wr_ident) |=> id_err_q)
    else $error("id error cleared without write");
  chk_vector_write: assert property (@(posedge i_mclk) // [RULE4]
    disable iff (i_reset) i_ce && wr_ident && !rst_q
    |=> o_backplane_vector_out == $past(wdata[ID_W-1:0]))
    else $error("vector does not follow id write");
  chk_foreign_silent: assert property (@(posedge i_mclk) // [RULE5]
    disable iff (i_reset) state_q == S_TA && !match_q |=> !o_mdio_oe)
    else $error("drove bus for another id");
  chk_strap_capture: assert property (@(posedge i_mclk) // [RULE6]
    i_ce && rst_q && !i_reset |=> own_repeater_number_q == $past(strap_s2))
    else $error("strap not captured");
  chk_counter_wrap: assert property (@(posedge i_mclk) // [RULE14]
    disable iff (i_reset) i_ce && count_en_q && i_short_event[2] &&
    !wr_commit && cnt_q[2] == 32'hFFFFFFFF |=> cnt_q[2] == 32'h00000000)
    else $error("counter did not wrap");
  chk_reset_clears: assert property (@(posedge i_mclk) // [RULE15]
    i_reset |=> cnt_q[0] == 32'h00000000 && cnt_q[7] == 32'h00000000)
    else $error("counter not cleared by reset");
  chk_upper_first: assert property (@(posedge i_mclk) // [RULE17]
    disable iff (i_reset) acc_rd && cnt_sel && !second
    |=> sh_q == $past(cnt_rd) ##0 half_q)
    else $error("first read not upper half");
  chk_mux_reset: assert property (@(posedge i_mclk) // [RULE18]
    disable iff (i_reset) i_ce && acc_any && !cnt_sel |=> !half_q)
    else $error("half mux kept across other access");
  chk_read_keeps: assert property (@(posedge i_mclk) // [RULE20]
    disable iff (i_reset) i_ce && acc_rd && !count_en_q
    |=> $stable(cnt_q[0]) && $stable(cnt_q[6]))
    else $error("read changed a counter");
  chk_split_write: assert property (@(posedge i_mclk) // [RULE23]
    disable iff (i_reset) i_ce && wr_commit && cnt_idx == 3'h2
    |=> cnt_q[2] == $past(commit_val))
    else $error("split write not committed");
endmodule : repeater_id_and_port_counters

// [verif/mgmt_master.sv]
`timescale 1ns/1ps
module mgmt_master (
  input wire logic i_mclk,
  input wire logic i_oe_dev,
  input wire logic i_out_dev,
  output logic o_mdc,
  output logic o_mdio,
  output logic o_rd_done,
  output logic [15:0] o_rd_data
);
  logic drv_q;
  logic bit_q;
  // Pull-up holds the line high whenever nobody drives it
  assign o_mdio = i_oe_dev ? i_out_dev : (drv_q ? bit_q : 1'b1);
  initial begin
    o_mdc = 1'b0;
    drv_q = 1'b0;
    bit_q = 1'b1;
    o_rd_done = 1'b0;
    o_rd_data = 16'h0000;
  end
  // One frame: 32 preamble ones, start, op, device, register, turn, data
  task automatic xfer(input logic rd, input logic [4:0] dev,
    input logic [4:0] rg, input logic [15:0] wd);
    logic [63:0] frm;
    logic [15:0] cap;
    frm = {32'hFFFFFFFF, 2'b01, rd ? 2'b10 : 2'b01, dev, rg, 2'b10, wd};
    cap = 16'h0000;
    for (int k = 0; k < 64; k++) begin
      @(negedge i_mclk);
      o_mdc = 1'b0;
      drv_q = !(rd && k > 45);
      bit_q = frm[63-k];
      repeat (4) @(negedge i_mclk);
      // Sampled just before the rise, the device bit has settled
      if (k > 47) cap = {cap[14:0], o_mdio};
      o_mdc = 1'b1;
      repeat (5) @(negedge i_mclk);
    end
    @(negedge i_mclk);
    o_mdc = 1'b0;
    drv_q = 1'b0;
    if (rd) begin
      o_rd_data = cap;
      o_rd_done = 1'b1;
      @(negedge i_mclk);
      o_rd_done = 1'b0;
    end
  endtask : xfer
endmodule : mgmt_master

// [verif/repeater_id_and_port_counters_bench.sv]
`timescale 1ns/1ps
module repeater_id_and_port_counters_bench;
  import rptr_mgmt_pkg::*;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic ce = 1'b1;
  logic [4:0] straps = 5'h0A;
  logic ee_bit = 1'b0;
  logic ee_v = 1'b0;
  logic clash = 1'b0;
  logic [7:0] sev = 8'h00;
  logic mdc, mdio, mdio_out, mdio_oe, cnt_en, ld_done, rd_done;
  logic [4:0] vec;
  logic [15:0] rd_data;
  logic [4:0] cur_id = 5'h0A;
  logic [31:0] rng = 32'h0000747D;
  logic [31:0] tag;
  logic [31:0] pre;
  logic [15:0] exp_q[$];
  int err_total = 0;
  int check_count = 0;
  localparam logic [4:0] B = REG_CNT_BASE;

  always #25 mclk = ~mclk;

  repeater_id_and_port_counters repeater_id_and_port_counters_i (
    .i_mclk(mclk), .i_reset(reset), .i_ce(ce), .i_id_strap_pins(straps),
    .i_mdc(mdc), .i_mdio_in(mdio), .i_ee_bit(ee_bit),
    .i_ee_bit_valid(ee_v), .i_id_clash(clash), .i_short_event(sev),
    .o_mdio_out(mdio_out), .o_mdio_oe(mdio_oe),
    .o_backplane_vector_out(vec), .o_stats_count_enable(cnt_en),
    .o_eeprom_load_complete(ld_done));

  mgmt_master mgmt_master_i (
    .i_mclk(mclk), .i_oe_dev(mdio_oe), .i_out_dev(mdio_out),
    .o_mdc(mdc), .o_mdio(mdio), .o_rd_done(rd_done),
    .o_rd_data(rd_data));

  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] x;
    x = v ^ (v << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs

  task automatic check(input string nm, input logic [31:0] e,
    input logic [31:0] s);
    check_count++;
    if (s !== e) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask : check

  task automatic test_done;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : test_done

  task automatic rd(input logic [4:0] rg, input logic [15:0] e);
    exp_q.push_back(e);
    mgmt_master_i.xfer(1'b1, cur_id, rg, 16'h0000);
  endtask : rd

  task automatic wr(input logic [4:0] rg, input logic [15:0] d);
    mgmt_master_i.xfer(1'b0, cur_id, rg, d);
  endtask : wr

  task automatic pulse(input logic [7:0] m);
    sev = m;
    @(negedge mclk);
    sev = 8'h00;
    @(negedge mclk);
  endtask : pulse

  always @(posedge mclk) begin
    if (rd_done === 1'b1) check("read data", exp_q.pop_front(), rd_data);
  end

  initial begin
    repeat (60000) @(posedge mclk);
    err_total++;
    test_done();
  end

  initial begin
    repeat (2) @(negedge mclk);
    reset = 1'b0;
    repeat (4) @(negedge mclk);
    check("vector", 32'(5'h0A), 32'(vec));
    check("load flag", 0, 32'(ld_done));
    rd(B, 16'h0000);
    rd(B, 16'h0000);
    $display("test reset done");
    for (int i = 0; i < 32; i++) begin
      rng = xs(rng);
      ee_bit = rng[0];
      ee_v = 1'b1;
      tag[i] = rng[0];
      @(negedge mclk);
      ee_v = 1'b0;
      @(negedge mclk);
    end
    check("load flag", 1, 32'(ld_done));
    rd(REG_HUB_LO, tag[15:0]);
    rd(REG_HUB_HI, tag[31:16]);
    rd(REG_IDENT, 16'h008A);
    cur_id = 5'h0B;
    rd(REG_IDENT, 16'hFFFF);
    cur_id = 5'h0A;
    $display("test eeprom and address done");
    wr(REG_CONFIG, 16'h0000);
    rng = xs(rng);
    pre = rng;
    wr(B, pre[31:16]);
    wr(B, pre[15:0]);
    rd(B, pre[31:16]);
    rd(REG_IDENT, 16'h008A);
    rd(B, pre[31:16]);
    rd(B, pre[15:0]);
    $display("test split access done");
    wr(B + 5'h02, 16'hFFFF);
    wr(B + 5'h02, 16'hFFFF);
    wr(REG_CONFIG, 16'h0001);
    check("count enable", 1, 32'(cnt_en));
    repeat (3) pulse(8'h04);
    wr(REG_CONFIG, 16'h0000);
    rd(B + 5'h02, 16'h0000);
    rd(B + 5'h02, 16'h0002);
    $display("test wrap done");
    wr(REG_CONFIG, 16'h0001);
    pulse(8'hFF);
    wr(REG_CONFIG, 16'h0000);
    wr(REG_PAGE, 16'h0001);
    rd(B + 5'h01, 16'h0000);
    rd(B + 5'h01, 16'h0001);
    wr(REG_PAGE, 16'h0000);
    rd(B + 5'h02, 16'h0000);
    rd(B + 5'h02, 16'h0003);
    wr(B, 16'h0000);
    wr(B, 16'h0000);
    rd(B, 16'h0000);
    rd(B, 16'h0000);
    $display("test pages and clear done");
    wr(REG_IDENT, 16'h0003);
    cur_id = 5'h03;
    check("vector", 32'(5'h03), 32'(vec));
    clash = 1'b1;
    @(negedge mclk);
    clash = 1'b0;
    rd(REG_IDENT, 16'h00A3);
    rd(REG_IDENT, 16'h00A3);
    wr(REG_IDENT, 16'h0003);
    rd(REG_IDENT, 16'h0083);
    $display("test identity done");
    // A write to a foreign ID must leave the page untouched
    cur_id = 5'h0B;
    wr(REG_PAGE, 16'h0001);
    cur_id = 5'h03;
    rd(REG_PAGE, 16'h0000);
    rd(REG_CONFIG, 16'h0000);
    // Low enable swallows the event; the next one counts
    wr(REG_CONFIG, 16'h0001);
    ce = 1'b0;
    pulse(8'h01);
    ce = 1'b1;
    pulse(8'h01);
    wr(REG_CONFIG, 16'h0000);
    rd(B, 16'h0000);
    rd(B, 16'h0001);
    $display("test enable and foreign write done");
    // Second reset with the illegal ID on the straps
    straps = ID_ILLEGAL;
    reset = 1'b1;
    repeat (2) @(negedge mclk);
    reset = 1'b0;
    repeat (4) @(negedge mclk);
    cur_id = ID_ILLEGAL;
    check("vector", 32'(ID_ILLEGAL), 32'(vec));
    check("load flag", 0, 32'(ld_done));
    rd(REG_IDENT, 16'h003F);
    rd(B + 5'h02, 16'h0000);
    rd(B + 5'h02, 16'h0000);
    wr(REG_IDENT, 16'h000A);
    cur_id = 5'h0A;
    rd(REG_IDENT, 16'h002A);
    wr(REG_IDENT, 16'h000A);
    rd(REG_IDENT, 16'h000A);
    $display("test second reset done");
    repeat (4) @(negedge mclk);
    test_done();
  end
endmodule : repeater_id_and_port_counters_bench
